// file: design/fwsu_top.sv
// flash wait-state control, flash signature engine and eeprom self-test registers
// Overview of operation
// - access time field sets latency plus one
// - one 128-bit signature over chosen range
// - range bounds counted in 128-bit flash words
// - runs alone; competing flash reads wait
// - first word register, 17 bits, resets zero
// - last word register, 17 bits, resets zero
// - bit 17 starts run, reads zero when stopped
// - stop address and go taken together
// - result read as four 32-bit words
// - reserved start/stop bits: write zeros only
// - eeprom first address even, 14 bits, resets zero
// - eeprom self-test steps even addresses only
// - completion flag set, held until cleared
// - eeprom go bit clears once test starts
`timescale 1ns/1ps
`default_nettype none
module fwsu_top (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // register port
  input wire fwsu_pkg::fwsu_bus_s bus,
  output logic [31:0] bus_rdata,
  // competing flash reads from the system bus
  input wire logic fl_rd_req,
  input wire logic [fwsu_pkg::FW_W-1:0] fl_rd_addr,
  output logic fl_rd_ack,
  output logic [fwsu_pkg::LINE_W-1:0] fl_rd_data,
  // flash array
  output fwsu_pkg::fwsu_arr_s arr,
  input wire logic [fwsu_pkg::LINE_W-1:0] arr_rdata,
  // eeprom self-test read port
  output logic ee_req,
  output logic [fwsu_pkg::EE_W-1:0] ee_addr,
  output logic ee_dev_lock,
  input wire logic ee_ack,
  input wire logic [15:0] ee_rdata
);
  typedef struct packed {
    logic [1:0] lat_code;
    logic [fwsu_pkg::FW_W-1:0] sig_first;
    logic [fwsu_pkg::FW_W-1:0] sig_last;
    logic sig_busy;
    logic generation_complete_flag;
    logic [fwsu_pkg::FW_W-1:0] sig_cur;
    fwsu_pkg::fwsu_acc_e acc_st;
    logic acc_sig;
    logic [1:0] acc_cnt;
    logic [fwsu_pkg::FW_W-1:0] acc_addr;
    logic rd_ack;
    logic [fwsu_pkg::LINE_W-1:0] rd_data;
    logic [31:0] rdata;
    logic [fwsu_pkg::EE_W-1:0] ee_first;
    logic [fwsu_pkg::EE_W-1:0] ee_last;
    logic ee_devsel;
    logic ee_go;
    logic ee_run;
    logic [fwsu_pkg::EE_W-1:0] ee_cur;
    logic [15:0] ee_data_sig;
    logic [15:0] ee_par_sig;
  } fwsu_state_s;

  fwsu_state_s q, d;
  logic [fwsu_pkg::LINE_W-1:0] sig_val;
  logic acc_fin;
  logic sig_step;
  logic go_wr;
  logic [31:0] rd_mux;

  assign acc_fin = (q.acc_st == fwsu_pkg::ACC_BUSY) && (q.acc_cnt == 2'h0);
  assign sig_step = acc_fin && q.acc_sig;
  // a go write while a run is active is ignored so the range cannot shift mid-run
  assign go_wr = bus.wr && (bus.addr == fwsu_pkg::OFS_SIG_LAST) &&
                 bus.wdata[fwsu_pkg::GO_BIT] && !q.sig_busy;

  fwsu_misr u_misr (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .clr(go_wr),
    .en(sig_step),
    .din(arr_rdata),
    .sig(sig_val)
  );

  // read data multiplexer; reserved and unmapped bits read as zero
  always_comb begin
    rd_mux = 32'h0000_0000;
    unique case (bus.addr)
      fwsu_pkg::OFS_ACCESS_CFG: rd_mux[1:0] = q.lat_code;
      fwsu_pkg::OFS_SIG_FIRST: rd_mux[fwsu_pkg::FW_W-1:0] = q.sig_first;
      fwsu_pkg::OFS_SIG_LAST: begin
        rd_mux[fwsu_pkg::FW_W-1:0] = q.sig_last;
        rd_mux[fwsu_pkg::GO_BIT] = q.sig_busy;
      end
      fwsu_pkg::OFS_SIG_W0: rd_mux = sig_val[31:0];
      fwsu_pkg::OFS_SIG_W1: rd_mux = sig_val[63:32];
      fwsu_pkg::OFS_SIG_W2: rd_mux = sig_val[95:64];
      fwsu_pkg::OFS_SIG_W3: rd_mux = sig_val[127:96];
      fwsu_pkg::OFS_EE_FIRST: rd_mux[fwsu_pkg::EE_W-1:0] = q.ee_first;
      fwsu_pkg::OFS_EE_LAST: begin
        rd_mux[fwsu_pkg::EE_W-1:0] = q.ee_last;
        rd_mux[fwsu_pkg::EE_DEVSEL_BIT] = q.ee_devsel;
        rd_mux[fwsu_pkg::EE_GO_BIT] = q.ee_go;
      end
      fwsu_pkg::OFS_EE_RESULT: rd_mux = {q.ee_par_sig, q.ee_data_sig};
      fwsu_pkg::OFS_FLAGS: rd_mux[fwsu_pkg::DONE_BIT] = q.generation_complete_flag;
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  always_comb begin
    d = q;
    d.rd_ack = 1'b0;
    d.rdata = bus.rd ? rd_mux : 32'h0000_0000;

    // register writes
    if (bus.wr) begin
      unique case (bus.addr)
        fwsu_pkg::OFS_ACCESS_CFG: d.lat_code = bus.wdata[1:0];
        fwsu_pkg::OFS_SIG_FIRST: begin
          if (!q.sig_busy) begin
            d.sig_first = bus.wdata[fwsu_pkg::FW_W-1:0];
          end
        end
        fwsu_pkg::OFS_SIG_LAST: begin
          if (!q.sig_busy) begin
            d.sig_last = bus.wdata[fwsu_pkg::FW_W-1:0];
          end
        end
        fwsu_pkg::OFS_EE_FIRST: begin
          d.ee_first = {bus.wdata[fwsu_pkg::EE_W-1:1], 1'b0};
        end
        fwsu_pkg::OFS_EE_LAST: begin
          d.ee_last = {bus.wdata[fwsu_pkg::EE_W-1:1], 1'b0};
          d.ee_devsel = bus.wdata[fwsu_pkg::EE_DEVSEL_BIT];
          if (bus.wdata[fwsu_pkg::EE_GO_BIT] && !q.ee_run) begin
            d.ee_go = 1'b1;
          end
        end
        fwsu_pkg::OFS_FLAG_CLR: begin
          if (bus.wdata[fwsu_pkg::DONE_BIT]) begin
            d.generation_complete_flag = 1'b0;
          end
        end
        default: d.generation_complete_flag = d.generation_complete_flag;
      endcase
    end

    // launch a signature run from the freshly written range
    if (go_wr) begin
      d.sig_busy = 1'b1;
      d.sig_cur = q.sig_first;
    end

    // shared flash access: the engine owns the array for the whole run
    unique case (q.acc_st)
      fwsu_pkg::ACC_IDLE: begin
        if (q.sig_busy) begin
          d.acc_st = fwsu_pkg::ACC_BUSY;
          d.acc_sig = 1'b1;
          d.acc_addr = q.sig_cur;
          d.acc_cnt = q.lat_code;
        end else if (fl_rd_req && !go_wr) begin
          d.acc_st = fwsu_pkg::ACC_BUSY;
          d.acc_sig = 1'b0;
          d.acc_addr = fl_rd_addr;
          d.acc_cnt = q.lat_code;
        end
      end
      fwsu_pkg::ACC_BUSY: begin
        if (q.acc_cnt != 2'h0) begin
          d.acc_cnt = q.acc_cnt - 2'h1;
        end else begin
          d.acc_st = fwsu_pkg::ACC_IDLE;
          if (!q.acc_sig) begin
            d.rd_ack = 1'b1;
            d.rd_data = arr_rdata;
          end
        end
      end
    endcase

    // walk the range; the completion flag set wins over a clear in the same cycle
    if (sig_step) begin
      if (q.sig_cur >= q.sig_last) begin
        d.sig_busy = 1'b0;
        d.generation_complete_flag = 1'b1;
      end else begin
        d.sig_cur = q.sig_cur + fwsu_pkg::FW_ONE;
      end
    end

    // eeprom self-test: go bit falls as the run begins
    if (q.ee_go && !q.ee_run) begin
      d.ee_go = 1'b0;
      d.ee_run = 1'b1;
      d.ee_cur = q.ee_first;
      d.ee_data_sig = 16'h0000;
      d.ee_par_sig = 16'h0000;
    end else if (q.ee_run && ee_ack) begin
      d.ee_data_sig = {q.ee_data_sig[14:0], 1'b0} ^ ee_rdata ^
                      (q.ee_data_sig[15] ? fwsu_pkg::EE_TAPS : 16'h0000);
      d.ee_par_sig = {q.ee_par_sig[14:0], q.ee_par_sig[15]} ^
                     {14'h0000, ^ee_rdata[15:8], ^ee_rdata[7:0]};
      if (q.ee_cur >= q.ee_last) begin
        d.ee_run = 1'b0;
      end else begin
        d.ee_cur = q.ee_cur + fwsu_pkg::EE_STEP;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      q <= '0;
      q.lat_code <= fwsu_pkg::LAT_CODE_RST;
      q.acc_st <= fwsu_pkg::ACC_IDLE;
    end else begin
      q <= d;
    end
  end

  assign bus_rdata = q.rdata;
  assign fl_rd_ack = q.rd_ack;
  assign fl_rd_data = q.rd_data;
  assign arr.en = (q.acc_st == fwsu_pkg::ACC_BUSY);
  assign arr.addr = q.acc_addr;
  assign ee_req = q.ee_run;
  assign ee_addr = q.ee_cur;
  assign ee_dev_lock = q.ee_devsel;

  // helper: cycles spent in the current access
  logic [2:0] acc_len_q;
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      acc_len_q <= 3'h0;
    end else if (q.acc_st == fwsu_pkg::ACC_BUSY && !acc_fin) begin
      acc_len_q <= acc_len_q + 3'h1;
    end else begin
      acc_len_q <= 3'h0;
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  access_latency_a: assert property (
    acc_fin |-> acc_len_q == {1'b0, q.lat_code}) else $error("flash access length wrong");
  read_stalled_a: assert property (
    q.sig_busy |-> !fl_rd_ack ##1 !fl_rd_ack) else $error("flash read served during run");
  go_launch_a: assert property (
    go_wr |=> q.sig_busy && q.sig_cur == $past(q.sig_first)) else $error("run not launched");
  last_taken_a: assert property (
    go_wr |=> q.sig_last == $past(bus.wdata[16:0])) else $error("stop address not taken");
  done_on_end_a: assert property (
    sig_step && q.sig_cur >= q.sig_last |=> q.generation_complete_flag && !q.sig_busy)
    else $error("completion not flagged");
  done_sticky_a: assert property (
    q.generation_complete_flag && !(bus.wr && bus.addr == fwsu_pkg::OFS_FLAG_CLR) |=> q.generation_complete_flag)
    else $error("completion flag lost");
  word1_read_a: assert property (
    bus.rd && bus.addr == fwsu_pkg::OFS_SIG_W1 |=> bus_rdata == $past(sig_val[63:32]))
    else $error("signature word 1 wrong");
  ee_even_addr_a: assert property (
    !ee_addr[0] && !q.ee_first[0]) else $error("odd eeprom address");
  ee_go_clear_a: assert property (
    q.ee_go |=> !q.ee_go && q.ee_run) else $error("eeprom go bit stuck");

  // register, run and eeprom checks; reads answer with the register state one cycle later
  cfg_read_a: assert property (
    bus.rd && bus.addr == fwsu_pkg::OFS_ACCESS_CFG |=>
      bus_rdata[1:0] == $past(q.lat_code)) else $error("latency code reads wrong");
  cfg_write_a: assert property (
    bus.wr && bus.addr == fwsu_pkg::OFS_ACCESS_CFG |=>
      q.lat_code == $past(bus.wdata[1:0])) else $error("latency code not stored");
  first_read_a: assert property (
    bus.rd && bus.addr == fwsu_pkg::OFS_SIG_FIRST |=>
      bus_rdata[fwsu_pkg::FW_W-1:0] == $past(q.sig_first)) else $error("first word wrong");
  last_read_a: assert property (
    bus.rd && bus.addr == fwsu_pkg::OFS_SIG_LAST |=>
      bus_rdata[fwsu_pkg::FW_W-1:0] == $past(q.sig_last)) else $error("last word wrong");
  busy_read_a: assert property (
    bus.rd && bus.addr == fwsu_pkg::OFS_SIG_LAST |=>
      bus_rdata[fwsu_pkg::GO_BIT] == $past(q.sig_busy)) else $error("run bit wrong");
  word0_read_a: assert property (
    bus.rd && bus.addr == fwsu_pkg::OFS_SIG_W0 |=>
      bus_rdata == $past(sig_val[31:0])) else $error("signature word 0 wrong");
  word2_read_a: assert property (
    bus.rd && bus.addr == fwsu_pkg::OFS_SIG_W2 |=>
      bus_rdata == $past(sig_val[95:64])) else $error("signature word 2 wrong");
  word3_read_a: assert property (
    bus.rd && bus.addr == fwsu_pkg::OFS_SIG_W3 |=>
      bus_rdata == $past(sig_val[127:96])) else $error("signature word 3 wrong");
  rdata_idle_a: assert property (
    !bus.rd |=>
      bus_rdata == 32'h0000_0000) else $error("read data not idle");
  flag_read_a: assert property (
    bus.rd && bus.addr == fwsu_pkg::OFS_FLAGS |=>
      bus_rdata[fwsu_pkg::DONE_BIT] == $past(q.generation_complete_flag)) else $error("flag reads wrong");
  clear_done_a: assert property (
    bus.wr && bus.addr == fwsu_pkg::OFS_FLAG_CLR &&
      bus.wdata[fwsu_pkg::DONE_BIT] && !sig_step |=> !q.generation_complete_flag)
    else $error("flag not cleared");
  range_locked_a: assert property (
    q.sig_busy |=>
      $stable(q.sig_first) && $stable(q.sig_last)) else $error("range moved in run");
  walk_step_a: assert property (
    sig_step && q.sig_cur < q.sig_last |=>
      q.sig_busy && q.sig_cur == $past(q.sig_cur) + fwsu_pkg::FW_ONE)
    else $error("range walk skipped");
  run_fetch_a: assert property (
    q.acc_st == fwsu_pkg::ACC_IDLE && q.sig_busy |=>
      arr.en && arr.addr == $past(q.sig_cur)) else $error("run fetch wrong");
  array_hold_a: assert property (
    arr.en && !acc_fin |=>
      arr.en && $stable(arr.addr)) else $error("array access cut short");
  ack_pulse_a: assert property (
    fl_rd_ack |=>
      !fl_rd_ack) else $error("read ack too long");
  ee_start_a: assert property (
    q.ee_go |=>
      ee_req && ee_addr == $past(q.ee_first)) else $error("eeprom run start wrong");
  ee_step_a: assert property (
    q.ee_run && ee_ack && q.ee_cur < q.ee_last |=>
      ee_addr == $past(ee_addr) + fwsu_pkg::EE_STEP) else $error("eeprom step wrong");
  ee_stop_a: assert property (
    q.ee_run && ee_ack && q.ee_cur >= q.ee_last |=>
      !ee_req) else $error("eeprom run not ended");
  ee_first_a: assert property (
    bus.wr && bus.addr == fwsu_pkg::OFS_EE_FIRST |=>
      q.ee_first == {$past(bus.wdata[fwsu_pkg::EE_W-1:1]), 1'b0})
    else $error("eeprom first wrong");

  run_done_c: cover property (go_wr ##[1:60] q.generation_complete_flag);
  stalled_read_c: cover property (q.sig_busy && fl_rd_req ##[1:60] fl_rd_ack);
  ee_run_c: cover property (q.ee_go ##[1:40] !q.ee_run);
  flag_clear_c: cover property (q.generation_complete_flag ##1 !q.generation_complete_flag);
  read_idle_c: cover property (fl_rd_ack && !q.sig_busy);
endmodule
`default_nettype wire

// file: design/fwsu_pkg.sv
// constants, register map and carrier types of the flash wait and signature unit
package fwsu_pkg;
  localparam int ADDR_W = 12;
  localparam int FW_W = 17;
  localparam int LINE_W = 128;
  localparam int EE_W = 14;
  // register offsets
  localparam logic [11:0] OFS_ACCESS_CFG = 12'h010;
  localparam logic [11:0] OFS_SIG_FIRST = 12'h020;
  localparam logic [11:0] OFS_SIG_LAST = 12'h024;
  localparam logic [11:0] OFS_SIG_W0 = 12'h02C;
  localparam logic [11:0] OFS_SIG_W1 = 12'h030;
  localparam logic [11:0] OFS_SIG_W2 = 12'h034;
  localparam logic [11:0] OFS_SIG_W3 = 12'h038;
  localparam logic [11:0] OFS_EE_FIRST = 12'h09C;
  localparam logic [11:0] OFS_EE_LAST = 12'h0A0;
  localparam logic [11:0] OFS_EE_RESULT = 12'h0A4;
  localparam logic [11:0] OFS_FLAGS = 12'hFE0;
  localparam logic [11:0] OFS_FLAG_CLR = 12'hFE8;
  // field positions and reset values
  localparam logic [1:0] LAT_CODE_RST = 2'h2;
  localparam int GO_BIT = 17;
  localparam int DONE_BIT = 2;
  localparam int EE_DEVSEL_BIT = 30;
  localparam int EE_GO_BIT = 31;
  localparam logic [FW_W-1:0] FW_ONE = 17'h00001;
  localparam logic [EE_W-1:0] EE_STEP = 14'h0002;
  // compressor feedback taps, arbitrary but fixed
  localparam logic [LINE_W-1:0] MISR_TAPS = 128'h0000_0000_0000_0000_0000_0000_0000_0087;
  localparam logic [15:0] EE_TAPS = 16'h1021;

  typedef enum logic [0:0] {
    ACC_IDLE = 1'b0,
    ACC_BUSY = 1'b1
  } fwsu_acc_e;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [ADDR_W-1:0] addr;
    logic [31:0] wdata;
  } fwsu_bus_s;

  typedef struct packed {
    logic en;
    logic [FW_W-1:0] addr;
  } fwsu_arr_s;
endpackage

// file: design/fwsu_misr.sv
// 128-bit multiple-input signature register for the flash signature engine
`timescale 1ns/1ps
`default_nettype none
module fwsu_misr (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // control
  input wire logic clr,
  input wire logic en,
  input wire logic [fwsu_pkg::LINE_W-1:0] din,
  // result
  output logic [fwsu_pkg::LINE_W-1:0] sig
);
  typedef struct packed {
    logic [fwsu_pkg::LINE_W-1:0] sig;
  } fwsu_misr_s;

  fwsu_misr_s q, d;

  always_comb begin
    d = q;
    if (clr) begin
      d.sig = '0;
    end else if (en) begin
      // shift, fold in the flash word, feed the top bit back through the taps
      d.sig = {q.sig[fwsu_pkg::LINE_W-2:0], 1'b0} ^ din ^
              (q.sig[fwsu_pkg::LINE_W-1] ? fwsu_pkg::MISR_TAPS : '0);
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign sig = q.sig;

  clear_zero_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    clr |=> sig == '0) else $error("signature not cleared");
endmodule
`default_nettype wire

// file: tb/fwsu_far_model.sv
// far-side model: flash array behind the block and the eeprom read port
`timescale 1ns/1ps
`default_nettype none
module fwsu_far_model (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // flash array
  input wire fwsu_pkg::fwsu_arr_s arr,
  output logic [127:0] arr_rdata,
  // eeprom
  input wire logic ee_req,
  input wire logic [13:0] ee_addr,
  output logic ee_ack,
  output logic [15:0] ee_rdata
);
  logic ph_q;
  logic take;
  assign take = ee_req & ~ee_ack & ph_q;
  // data lags the address a cycle and is garbled outside an access, so a
  // design sampling too early or too late sees wrong words
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      arr_rdata <= '0;
      ee_ack <= 1'b0;
      ee_rdata <= '0;
      ph_q <= 1'b0;
    end else begin
      arr_rdata <= arr.en ? {4{arr.addr[15:0], ~arr.addr[15:0]}} : ~arr_rdata;
      ph_q <= ~ph_q;
      ee_ack <= take;
      ee_rdata <= take ? (16'hC300 ^ {2'h0, ee_addr}) : ~ee_rdata;
    end
  end
endmodule
`default_nettype wire

// file: tb/testbench.sv
// self-checking bench for the flash wait and signature unit
`timescale 1ns/1ps
`default_nettype none
module testbench;
  typedef struct packed {
    logic [11:0] a;
    logic w;
    logic [31:0] d;
    logic [31:0] e;
  } fwsu_row_s;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  fwsu_pkg::fwsu_bus_s bus = '0;
  logic [31:0] bus_rdata, r;
  logic fl_rd_req = 1'b0;
  logic [16:0] fl_rd_addr = '0;
  logic fl_rd_ack, ee_req, ee_dev_lock, ee_ack;
  logic [127:0] fl_rd_data, arr_rdata, s;
  fwsu_pkg::fwsu_arr_s arr;
  logic [13:0] ee_addr;
  logic [15:0] ee_rdata, d, p, ev;
  int fails = 0;
  int n_tests = 0;
  int n;
  fwsu_row_s rows[12] = '{
    '{12'h010, 1'b0, 32'h0, 32'h2},
    '{12'h020, 1'b0, 32'h0, 32'h0},
    '{12'h024, 1'b0, 32'h0, 32'h0},
    '{12'h09C, 1'b0, 32'h0, 32'h0},
    '{12'h0A4, 1'b0, 32'h0, 32'h0},
    '{12'hFE0, 1'b0, 32'h0, 32'h0},
    '{12'h010, 1'b1, 32'h00000003, 32'h3},
    '{12'h020, 1'b1, 32'h0001FFFF, 32'h1FFFF},
    '{12'h024, 1'b1, 32'h0001FFFF, 32'h1FFFF},
    '{12'h09C, 1'b1, 32'h00003FFF, 32'h3FFE},
    '{12'h100, 1'b1, 32'hFFFFFFFF, 32'h0},
    '{12'h0A0, 1'b1, 32'h40003FFF, 32'h40003FFE}};

  always #12.5 sys_clk = ~sys_clk;

  fwsu_top u_dut (.sys_clk(sys_clk), .rst_n(rst_n), .bus(bus), .bus_rdata(bus_rdata),
    .fl_rd_req(fl_rd_req), .fl_rd_addr(fl_rd_addr), .fl_rd_ack(fl_rd_ack),
    .fl_rd_data(fl_rd_data), .arr(arr), .arr_rdata(arr_rdata), .ee_req(ee_req),
    .ee_addr(ee_addr), .ee_dev_lock(ee_dev_lock), .ee_ack(ee_ack), .ee_rdata(ee_rdata));
  fwsu_far_model u_far (.sys_clk(sys_clk), .rst_n(rst_n), .arr(arr), .arr_rdata(arr_rdata),
    .ee_req(ee_req), .ee_addr(ee_addr), .ee_ack(ee_ack), .ee_rdata(ee_rdata));

  function automatic logic [127:0] pat(input logic [16:0] a);
    return {4{a[15:0], ~a[15:0]}};
  endfunction

  task automatic chk(input string nm, input logic [127:0] got, input logic [127:0] exp);
    n_tests++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] v);
    @(posedge sys_clk) bus <= '{1'b1, 1'b0, a, v};
    @(posedge sys_clk) bus <= '0;
  endtask

  task automatic rd(input logic [11:0] a, output logic [31:0] v);
    @(posedge sys_clk) bus <= '{1'b0, 1'b1, a, 32'h0};
    @(posedge sys_clk) bus <= '0;
    #1 v = bus_rdata;
  endtask

  // request held until the ack; n counts edges from the taking edge
  task automatic frd(input logic [16:0] a, output int k);
    @(posedge sys_clk) begin
      fl_rd_req <= 1'b1;
      fl_rd_addr <= a;
    end
    k = 0;
    while (fl_rd_ack !== 1'b1 && k < 300) begin
      @(posedge sys_clk);
      #1 k++;
    end
    chk("flash data", fl_rd_data, pat(a));
    @(posedge sys_clk) fl_rd_req <= 1'b0;
    repeat (8) @(posedge sys_clk);
  endtask

  task automatic close_out;
    if (fails == 0 && n_tests > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  always @(negedge sys_clk) begin
    if (ee_req === 1'b1)
      chk("even eeprom addr", ee_addr[0], 1'b0);
  end

  initial begin
    repeat (20000) @(posedge sys_clk);
    fails++;
    close_out;
  end

  initial begin
    repeat (6) @(posedge sys_clk);
    rst_n <= 1'b1;
    foreach (rows[i]) begin
      if (rows[i].w)
        wr(rows[i].a, rows[i].d);
      rd(rows[i].a, r);
      chk("register", r, rows[i].e);
    end
    chk("eeprom device lock", ee_dev_lock, 1'b1);
    for (int c = 2; c <= 3; c++) begin
      wr(fwsu_pkg::OFS_ACCESS_CFG, 32'(c));
      frd(17'h00010 + 17'(c), n);
      chk("latency", n, c + 2);
    end
    wr(fwsu_pkg::OFS_FLAG_CLR, 32'h4);
    wr(fwsu_pkg::OFS_SIG_FIRST, 32'h2);
    wr(fwsu_pkg::OFS_SIG_LAST, 32'h00020004);
    wr(fwsu_pkg::OFS_SIG_FIRST, 32'h7);
    rd(fwsu_pkg::OFS_SIG_LAST, r);
    chk("busy bit", r[17], 1'b1);
    frd(17'h00005, n);
    chk("stalled read", n > 8, 1'b1);
    rd(fwsu_pkg::OFS_FLAGS, r);
    chk("done flag", r[2], 1'b1);
    s = '0;
    for (int w = 2; w <= 4; w++)
      s = (s << 1) ^ pat(17'(w)) ^ (s[127] ? fwsu_pkg::MISR_TAPS : '0);
    for (int k = 0; k < 4; k++) begin
      rd(fwsu_pkg::OFS_SIG_W0 + 12'(4 * k), r);
      chk("signature word", r, s[32 * k +: 32]);
    end
    rd(fwsu_pkg::OFS_SIG_FIRST, r);
    chk("first kept in run", r, 32'h2);
    rd(fwsu_pkg::OFS_SIG_LAST, r);
    chk("stopped", r, 32'h4);
    wr(fwsu_pkg::OFS_FLAG_CLR, 32'h4);
    rd(fwsu_pkg::OFS_FLAGS, r);
    chk("flag cleared", r[2], 1'b0);
    wr(fwsu_pkg::OFS_EE_FIRST, 32'h4);
    wr(fwsu_pkg::OFS_EE_LAST, 32'h80000008);
    rd(fwsu_pkg::OFS_EE_LAST, r);
    chk("eeprom go clears", r, 32'h8);
    n = 0;
    while (ee_req === 1'b1 && n < 200) begin
      @(posedge sys_clk);
      n++;
    end
    d = '0;
    p = '0;
    for (int a = 4; a <= 8; a += 2) begin
      ev = 16'hC300 ^ 16'(a);
      d = (d << 1) ^ ev ^ (d[15] ? fwsu_pkg::EE_TAPS : 16'h0);
      p = {p[14:0], p[15]} ^ {14'h0, ^ev[15:8], ^ev[7:0]};
    end
    rd(fwsu_pkg::OFS_EE_RESULT, r);
    chk("eeprom data sig", r[15:0], d);
    chk("eeprom parity sig", r[31:16], p);
    chk("eeprom device lock clear", ee_dev_lock, 1'b0);
    // reset after both runs have ended: registers must fall back to their reset values
    @(posedge sys_clk) rst_n <= 1'b0;
    repeat (2) @(posedge sys_clk);
    rst_n <= 1'b1;
    rd(fwsu_pkg::OFS_ACCESS_CFG, r);
    chk("latency code after reset", r, 32'h2);
    rd(fwsu_pkg::OFS_SIG_LAST, r);
    chk("last word after reset", r, 32'h0);
    rd(fwsu_pkg::OFS_EE_FIRST, r);
    chk("eeprom first after reset", r, 32'h0);
    close_out;
  end
endmodule
`default_nettype wire
